// file: hw/fmsp_consts.svh
`ifndef FMSP_CONSTS_SVH
`define FMSP_CONSTS_SVH
// Register offsets
`define FMSP_OFS_CTRL_HIGH 8'h14
`define FMSP_OFS_CTRL_LOW 8'h15
`define FMSP_OFS_DATA 8'h16
`define FMSP_OFS_BAUD 8'h17
// Reset values
`define FMSP_CTRL_HIGH_RST 8'h00
`define FMSP_CTRL_LOW_RST 8'h00
`define FMSP_BAUD_RST 8'h00
// High control byte fields
`define FMSP_H_MODE_HI 7
`define FMSP_H_MODE_LO 6
`define FMSP_H_MPE 5
`define FMSP_H_RXEN 4
`define FMSP_H_TX9 3
`define FMSP_H_RX9 2
`define FMSP_H_RXIE 1
`define FMSP_H_RXPEND 0
// Low control byte fields
`define FMSP_L_TXIE 1
`define FMSP_L_TXPEND 0
// Last of the sixteen sample ticks of a bit, and tick of the bit midpoint
`define FMSP_TICKS_PER_BIT 4'hF
`define FMSP_MID_TICK 4'h7
`endif

// file: hw/fmsp_pkg.sv
package fmsp_pkg;
	typedef enum logic [1:0] {FMSP_MODE_SHIFT, FMSP_MODE_ASYNC8, FMSP_MODE_ASYNC9F,
		FMSP_MODE_ASYNC9V} fmsp_mode_t;
	typedef enum {FMSP_TX_IDLE, FMSP_TX_START, FMSP_TX_DATA, FMSP_TX_NINTH,
		FMSP_TX_STOP} fmsp_tx_state_t;
	typedef enum {FMSP_RX_IDLE, FMSP_RX_START, FMSP_RX_DATA, FMSP_RX_NINTH,
		FMSP_RX_STOP} fmsp_rx_state_t;
endpackage

// file: hw/fmsp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_consts.svh"
// Operation
// - Four modes: shift, 8-bit async variable, 9-bit async clk/16, 9-bit async variable.
// - Shift mode rate is clock over sixteen times divisor plus one.
// - Fixed 9-bit mode rate is clock over sixteen regardless of divisor.
// - 8-bit and variable 9-bit modes use clock over sixteen times divisor plus one.
// - Data writes load transmit buffer; data reads return separate receive buffer.
// - Receiver may shift a new byte before the old is read; overrun loses one.
// - Any write to the data address starts transmission in every mode.
// - Shift mode reception starts when receive pending is 0 and enable is 1.
// - Async reception starts on a low start bit while receive is enabled.
// - Shift mode sets receive pending after the eighth bit shifted in.
// - 8-bit async mode sets receive pending at the stop bit midpoint.
// - 9-bit modes set receive pending at the ninth bit midpoint.
// - Shift mode sets transmit pending after the eighth bit shifted out.
// - Async modes set transmit pending at the start of the stop bit.
// - Pending flag with matching enable raises an interrupt request.
// - Reset clears both control bytes to zero.
// - High byte: mode, multiproc, enable, ninth bits, receive irq; low: tx irq.
// - Ninth bit fields act only in the two 9-bit modes.
// - Shift mode: 8 bits LSB first on input pin, output pin drives clock.
// - 8-bit frame: low start, eight data LSB first, high stop.
// - 9-bit frame adds ninth bit from field; received ninth stored, stop ignored.
// - Multiproc enable in 9-bit modes suppresses receive pending for frames with ninth bit zero.
module fmsp_serial_port (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic serial_in_pin,
	output logic serial_in_oe,
	output logic serial_in_out,
	output logic serial_out_pin,
	output logic rx_irq,
	output logic tx_irq
);
	logic [7:0] ctrl_high_reg;
	logic [7:0] ctrl_low_reg;
	logic [7:0] baud_divisor_reg;
	logic [7:0] tx_buf_reg;
	logic [7:0] rx_buf_reg;
	logic [7:0] baud_cnt_reg;
	logic tick;
	logic [2:0] in_sync_reg;
	logic rx_line_reg;
	fmsp_pkg::fmsp_mode_t mode;
	logic nine_bit;
	logic rx_set;
	logic tx_set;
	logic rx_ninth_set;
	logic rx_ninth_val;

	assign mode = fmsp_pkg::fmsp_mode_t'(ctrl_high_reg[`FMSP_H_MODE_HI:`FMSP_H_MODE_LO]);
	assign nine_bit = (mode == fmsp_pkg::FMSP_MODE_ASYNC9F) ||
		(mode == fmsp_pkg::FMSP_MODE_ASYNC9V);

	wire wr_high = reg_wr && (reg_addr == `FMSP_OFS_CTRL_HIGH);
	wire wr_low = reg_wr && (reg_addr == `FMSP_OFS_CTRL_LOW);
	wire wr_data = reg_wr && (reg_addr == `FMSP_OFS_DATA);
	wire wr_baud = reg_wr && (reg_addr == `FMSP_OFS_BAUD);

	// Baud tick: fixed mode ticks every clock, others reload from divisor
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			baud_cnt_reg <= 8'h00;
		else if (mode == fmsp_pkg::FMSP_MODE_ASYNC9F || baud_cnt_reg == 8'h00)
			baud_cnt_reg <= baud_divisor_reg;
		else
			baud_cnt_reg <= baud_cnt_reg - 8'h01;
	end
	assign tick = (mode == fmsp_pkg::FMSP_MODE_ASYNC9F) || (baud_cnt_reg == 8'h00);

	// Input pin synchroniser; change taken when stages two and three agree
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			in_sync_reg <= 3'h7;
			rx_line_reg <= 1'b1;
		end
		else
		begin
			in_sync_reg <= {in_sync_reg[1:0], serial_in_pin};
			if (in_sync_reg[1] == in_sync_reg[2])
				rx_line_reg <= in_sync_reg[2];
		end
	end

	// Registers
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_high_reg <= `FMSP_CTRL_HIGH_RST;
			ctrl_low_reg <= `FMSP_CTRL_LOW_RST;
			baud_divisor_reg <= `FMSP_BAUD_RST;
			tx_buf_reg <= 8'h00;
		end
		else
		begin
			if (wr_high)
			begin
				ctrl_high_reg[7:3] <= reg_wdata[7:3];
				ctrl_high_reg[`FMSP_H_RXIE] <= reg_wdata[`FMSP_H_RXIE];
			end
			if (rx_ninth_set)
				ctrl_high_reg[`FMSP_H_RX9] <= rx_ninth_val;
			else if (wr_high)
				ctrl_high_reg[`FMSP_H_RX9] <= reg_wdata[`FMSP_H_RX9];
			// Hardware set wins over a software clear
			if (rx_set)
				ctrl_high_reg[`FMSP_H_RXPEND] <= 1'b1;
			else if (wr_high)
				ctrl_high_reg[`FMSP_H_RXPEND] <= reg_wdata[`FMSP_H_RXPEND];
			if (wr_low)
				ctrl_low_reg[7:1] <= reg_wdata[7:1];
			if (tx_set)
				ctrl_low_reg[`FMSP_L_TXPEND] <= 1'b1;
			else if (wr_low)
				ctrl_low_reg[`FMSP_L_TXPEND] <= reg_wdata[`FMSP_L_TXPEND];
			if (wr_baud)
				baud_divisor_reg <= reg_wdata;
			if (wr_data)
				tx_buf_reg <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			unique case (reg_addr)
				`FMSP_OFS_CTRL_HIGH: reg_rdata <= ctrl_high_reg;
				`FMSP_OFS_CTRL_LOW: reg_rdata <= ctrl_low_reg;
				`FMSP_OFS_DATA: reg_rdata <= rx_buf_reg;
				`FMSP_OFS_BAUD: reg_rdata <= baud_divisor_reg;
				default: reg_rdata <= 8'h00;
			endcase
		else
			reg_rdata <= 8'h00;
	end

	assign rx_irq = ctrl_high_reg[`FMSP_H_RXPEND] && ctrl_high_reg[`FMSP_H_RXIE];
	assign tx_irq = ctrl_low_reg[`FMSP_L_TXPEND] && ctrl_low_reg[`FMSP_L_TXIE];

	// Transmitter
	fmsp_pkg::fmsp_tx_state_t tx_state_reg;
	logic [3:0] tx_tick_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_shift_reg;
	logic tx_ninth_reg;
	logic sclk_reg;
	logic sdo_reg;
	logic rx_shift_busy;
	wire tx_bit_end = tick && (tx_tick_reg == `FMSP_TICKS_PER_BIT);
	wire tx_half = tick && (tx_tick_reg == `FMSP_MID_TICK);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_state_reg <= fmsp_pkg::FMSP_TX_IDLE;
			tx_tick_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_ninth_reg <= 1'b0;
			serial_out_pin <= 1'b1;
			sclk_reg <= 1'b1;
			sdo_reg <= 1'b1;
			tx_set <= 1'b0;
		end
		else
		begin
			tx_set <= 1'b0;
			if (tick)
				tx_tick_reg <= tx_tick_reg + 4'h1;
			if (wr_data)
			begin
				tx_shift_reg <= reg_wdata;
				tx_ninth_reg <= ctrl_high_reg[`FMSP_H_TX9];
				tx_tick_reg <= 4'h0;
				tx_bit_reg <= 3'h0;
				tx_state_reg <= (mode == fmsp_pkg::FMSP_MODE_SHIFT) ?
					fmsp_pkg::FMSP_TX_DATA : fmsp_pkg::FMSP_TX_START;
				if (mode == fmsp_pkg::FMSP_MODE_SHIFT)
					sdo_reg <= reg_wdata[0];
				else
					serial_out_pin <= 1'b0;
			end
			else if (mode == fmsp_pkg::FMSP_MODE_SHIFT)
			begin
				// Output pin carries the shift clock; high half then low half
				if (tx_state_reg == fmsp_pkg::FMSP_TX_DATA || rx_shift_busy)
				begin
					if (tx_half)
						serial_out_pin <= 1'b0;
					if (tx_bit_end)
						serial_out_pin <= 1'b1;
				end
				else
					serial_out_pin <= 1'b1;
				if (tx_state_reg == fmsp_pkg::FMSP_TX_DATA && tx_bit_end)
				begin
					tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
					sdo_reg <= tx_shift_reg[1];
					tx_bit_reg <= tx_bit_reg + 3'h1;
					if (tx_bit_reg == 3'h7)
					begin
						tx_state_reg <= fmsp_pkg::FMSP_TX_IDLE;
						tx_set <= 1'b1;
						sdo_reg <= 1'b1;
					end
				end
			end
			else if (tx_bit_end)
			begin
				unique case (tx_state_reg)
					fmsp_pkg::FMSP_TX_IDLE: serial_out_pin <= 1'b1;
					fmsp_pkg::FMSP_TX_START:
					begin
						tx_state_reg <= fmsp_pkg::FMSP_TX_DATA;
						serial_out_pin <= tx_shift_reg[0];
					end
					fmsp_pkg::FMSP_TX_DATA:
					begin
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						tx_bit_reg <= tx_bit_reg + 3'h1;
						serial_out_pin <= tx_shift_reg[1];
						if (tx_bit_reg == 3'h7)
						begin
							if (nine_bit)
							begin
								tx_state_reg <= fmsp_pkg::FMSP_TX_NINTH;
								serial_out_pin <= tx_ninth_reg;
							end
							else
							begin
								tx_state_reg <= fmsp_pkg::FMSP_TX_STOP;
								serial_out_pin <= 1'b1;
								tx_set <= 1'b1;
							end
						end
					end
					fmsp_pkg::FMSP_TX_NINTH:
					begin
						tx_state_reg <= fmsp_pkg::FMSP_TX_STOP;
						serial_out_pin <= 1'b1;
						tx_set <= 1'b1;
					end
					fmsp_pkg::FMSP_TX_STOP: tx_state_reg <= fmsp_pkg::FMSP_TX_IDLE;
				endcase
			end
		end
	end

	// Receiver
	fmsp_pkg::fmsp_rx_state_t rx_state_reg;
	logic [3:0] rx_tick_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;
	wire rx_mid = tick && (rx_tick_reg == `FMSP_MID_TICK);
	wire rx_en = ctrl_high_reg[`FMSP_H_RXEN];
	wire mpe = ctrl_high_reg[`FMSP_H_MPE];
	assign rx_shift_busy = (mode == fmsp_pkg::FMSP_MODE_SHIFT) &&
		(rx_state_reg == fmsp_pkg::FMSP_RX_DATA);
	// Shift mode drives the in pin only while transmitting
	assign serial_in_oe = (mode == fmsp_pkg::FMSP_MODE_SHIFT) &&
		(tx_state_reg == fmsp_pkg::FMSP_TX_DATA);
	assign serial_in_out = sdo_reg;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_state_reg <= fmsp_pkg::FMSP_RX_IDLE;
			rx_tick_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_buf_reg <= 8'h00;
			rx_set <= 1'b0;
			rx_ninth_set <= 1'b0;
			rx_ninth_val <= 1'b0;
		end
		else
		begin
			rx_set <= 1'b0;
			rx_ninth_set <= 1'b0;
			if (tick)
				rx_tick_reg <= rx_tick_reg + 4'h1;
			if (!rx_en)
				rx_state_reg <= fmsp_pkg::FMSP_RX_IDLE;
			else
				unique case (rx_state_reg)
					fmsp_pkg::FMSP_RX_IDLE:
					begin
						rx_bit_reg <= 3'h0;
						rx_tick_reg <= 4'h0;
						if (mode == fmsp_pkg::FMSP_MODE_SHIFT)
						begin
							// Pending lands a cycle after the set pulse; no restart meanwhile
							if (!ctrl_high_reg[`FMSP_H_RXPEND] && !rx_set)
								rx_state_reg <= fmsp_pkg::FMSP_RX_DATA;
						end
						else if (!rx_line_reg)
							rx_state_reg <= fmsp_pkg::FMSP_RX_START;
					end
					fmsp_pkg::FMSP_RX_START:
						if (rx_mid)
						begin
							rx_tick_reg <= 4'h8;
							// False start if line returned high
							rx_state_reg <= rx_line_reg ? fmsp_pkg::FMSP_RX_IDLE :
								fmsp_pkg::FMSP_RX_DATA;
						end
					fmsp_pkg::FMSP_RX_DATA:
						// Sample at bit midpoint; shift mode samples at clock rise
						if ((mode == fmsp_pkg::FMSP_MODE_SHIFT) ?
							(tx_bit_end && !serial_out_pin) : rx_mid)
						begin
							rx_shift_reg <= {rx_line_reg, rx_shift_reg[7:1]};
							rx_bit_reg <= rx_bit_reg + 3'h1;
							if (rx_bit_reg == 3'h7)
							begin
								if (mode == fmsp_pkg::FMSP_MODE_SHIFT)
								begin
									rx_buf_reg <= {rx_line_reg, rx_shift_reg[7:1]};
									rx_set <= 1'b1;
									rx_state_reg <= fmsp_pkg::FMSP_RX_IDLE;
								end
								else
									rx_state_reg <= nine_bit ? fmsp_pkg::FMSP_RX_NINTH :
										fmsp_pkg::FMSP_RX_STOP;
							end
						end
					fmsp_pkg::FMSP_RX_NINTH:
						if (rx_mid)
						begin
							rx_buf_reg <= rx_shift_reg;
							rx_ninth_set <= 1'b1;
							rx_ninth_val <= rx_line_reg;
							rx_set <= !(mpe && !rx_line_reg);
							rx_state_reg <= fmsp_pkg::FMSP_RX_IDLE;
						end
					fmsp_pkg::FMSP_RX_STOP:
						if (rx_mid)
						begin
							rx_buf_reg <= rx_shift_reg;
							rx_set <= 1'b1;
							rx_state_reg <= fmsp_pkg::FMSP_RX_IDLE;
						end
				endcase
		end
	end
endmodule
`default_nettype wire

// file: bench/fmsp_serial_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_consts.svh"
module fmsp_serial_port_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic serial_in_pin,
	input wire logic serial_in_oe,
	input wire logic serial_in_out,
	input wire logic serial_out_pin,
	input wire logic rx_irq,
	input wire logic tx_irq
);
	logic [1:0] mode_q;
	logic rxie_q;
	logic dw;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Shadow of the mode and receive interrupt enable fields
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			mode_q <= 2'h0;
			rxie_q <= 1'b0;
		end
		else if (reg_wr && reg_addr == `FMSP_OFS_CTRL_HIGH)
		begin
			mode_q <= reg_wdata[7:6];
			rxie_q <= reg_wdata[1];
		end
	end
	assign dw = reg_wr && reg_addr == `FMSP_OFS_DATA;
	sequence low_bit_s;
		(!serial_out_pin)[*8] ##1 (!serial_out_pin)[*8];
	endsequence
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read answer");
	tx_start_a: assert property (dw && mode_q != 2'h0 |-> ##[1:2] !serial_out_pin)
		else $error("no start bit after data write");
	stop_flag_a: assert property ($rose(tx_irq) && mode_q != 2'h0 |-> serial_out_pin)
		else $error("transmit flag rose outside stop bit");
	rx_gate_a: assert property ($rose(rx_irq) |-> rxie_q)
		else $error("receive request without enable");
	rx_off_a: assert property (reg_wr && reg_addr == `FMSP_OFS_CTRL_HIGH && !reg_wdata[1]
		|=> !rx_irq)
		else $error("receive request while disabled");
	tx_off_a: assert property (reg_wr && reg_addr == `FMSP_OFS_CTRL_LOW && !reg_wdata[1]
		|=> !tx_irq)
		else $error("transmit request while disabled");
	oe_mode_a: assert property (serial_in_oe |-> mode_q == 2'h0)
		else $error("data pin driven outside shift mode");
	bit_time_a: assert property ($fell(serial_out_pin) && mode_q == 2'h2 |-> low_bit_s)
		else $error("fixed mode bit shorter than sixteen clocks");
endmodule
bind fmsp_serial_port fmsp_serial_port_checker chk_u (
	.sys_clk(sys_clk),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.serial_in_pin(serial_in_pin),
	.serial_in_oe(serial_in_oe),
	.serial_in_out(serial_in_out),
	.serial_out_pin(serial_out_pin),
	.rx_irq(rx_irq),
	.tx_irq(tx_irq)
);
`default_nettype wire

// file: bench/fmsp_remote_node.sv
`timescale 1ns/1ps
`default_nettype none
module fmsp_remote_node (
	input wire logic sys_clk,
	input wire logic sclk,
	output logic line
);
	initial line = 1'b1;
	// Line rests at its pull-up level between frames
	task automatic send(input logic [8:0] d, input int nb, input int bt);
		line <= 1'b0;
		repeat (bt) @(posedge sys_clk);
		for (int i = 0; i < nb; i++)
		begin
			line <= d[i];
			repeat (bt) @(posedge sys_clk);
		end
		line <= 1'b1;
		repeat (bt) @(posedge sys_clk);
	endtask
	// Shift peripheral: next bit after each clock fall, line freed after the last rise
	task automatic shift_send(input logic [7:0] d);
		logic p;
		for (int i = 0; i < 8; i++)
		begin
			do
			begin
				p = sclk;
				@(posedge sys_clk);
			end
			while (!(p && !sclk));
			line <= d[i];
		end
		do
		begin
			p = sclk;
			@(posedge sys_clk);
		end
		while (p || !sclk);
		line <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk, rst, reg_wr, reg_rd, rx_line, serial_in_pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic serial_in_oe, serial_in_out, serial_out_pin, rx_irq, tx_irq;
	int fail_count = 0;
	int num_checks = 0;
	fmsp_serial_port dut_u (
		.sys_clk(sys_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.serial_in_pin(serial_in_pin),
		.serial_in_oe(serial_in_oe),
		.serial_in_out(serial_in_out),
		.serial_out_pin(serial_out_pin),
		.rx_irq(rx_irq),
		.tx_irq(tx_irq)
	);
	fmsp_remote_node node_u (
		.sys_clk(sys_clk),
		.sclk(serial_out_pin),
		.line(rx_line)
	);
	assign serial_in_pin = serial_in_oe ? serial_in_out : rx_line;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// Idle edge so a following call never drives the strobe twice in one step
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
		@(posedge sys_clk);
	endtask
	task automatic t_reset();
		rd(8'h14, 8'h00);
		rd(8'h15, 8'h00);
		rd(8'h20, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_tx(input logic [1:0] m, input logic n9, input logic [7:0] d);
		int bt;
		int nb;
		logic [10:0] f;
		bt = (m == 2'h2) ? 16 : 32;
		nb = (m == 2'h1) ? 10 : 11;
		f = {1'b1, (m == 2'h1) | n9, d, 1'b0};
		wr(8'h17, 8'h01);
		wr(8'h15, 8'h02);
		wr(8'h14, {m, 2'b00, n9, 3'b000});
		chk({7'h00, tx_irq}, 8'h00);
		wr(8'h16, d);
		repeat (bt / 2) @(posedge sys_clk);
		for (int i = 0; i < nb; i++)
		begin
			#1;
			chk({7'h00, serial_out_pin}, {7'h00, f[i]});
			chk({7'h00, tx_irq}, {7'h00, i == nb - 1});
			repeat (bt) @(posedge sys_clk);
		end
		$display("test transmit done");
	endtask
	task automatic t_rx(input logic [1:0] m, input logic mpe, input logic n9,
		input logic [7:0] d, input logic e);
		int bt;
		bt = (m == 2'h2) ? 16 : 32;
		wr(8'h14, {m, mpe, 5'b10010});
		node_u.send({n9, d}, (m == 2'h1) ? 8 : 9, bt);
		repeat (4) @(posedge sys_clk);
		#1;
		chk({7'h00, rx_irq}, {7'h00, e});
		@(posedge sys_clk);
		if (e)
		begin
			rd(8'h16, d);
			rd(8'h14, {m, mpe, 2'b10, n9 & (m != 2'h1), 2'b11});
		end
		wr(8'h14, {m, mpe, 5'b10010});
		#1;
		chk({7'h00, rx_irq}, 8'h00);
		@(posedge sys_clk);
		$display("test receive done");
	endtask
	task automatic t_shift(input logic [7:0] d);
		int n;
		logic p;
		logic q;
		n = 0;
		p = 1'b1;
		q = 1'b1;
		wr(8'h15, 8'h02);
		wr(8'h14, 8'h00);
		wr(8'h16, d);
		repeat (300)
		begin
			@(posedge sys_clk);
			#1;
			// A peripheral takes the data that stood just before the clock rise
			if (serial_out_pin && !p && n < 8)
			begin
				chk({7'h00, q}, {7'h00, d[n]});
				n++;
			end
			p = serial_out_pin;
			q = serial_in_pin;
		end
		chk(8'(n), 8'h08);
		chk({7'h00, tx_irq}, 8'h01);
		chk({7'h00, serial_in_oe}, 8'h00);
		@(posedge sys_clk);
		$display("test shift done");
	endtask
	task automatic t_shift_rx(input logic [7:0] d);
		wr(8'h14, 8'h12);
		node_u.shift_send(d);
		repeat (20) @(posedge sys_clk);
		#1;
		chk({7'h00, rx_irq}, 8'h01);
		chk({7'h00, serial_out_pin}, 8'h01);
		@(posedge sys_clk);
		rd(8'h16, d);
		wr(8'h14, 8'h00);
		$display("test shift receive done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		results();
	end
	initial
	begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_tx(2'h1, 1'b1, 8'hA5);
		t_tx(2'h2, 1'b0, 8'h3C);
		t_tx(2'h3, 1'b1, 8'h96);
		t_rx(2'h1, 1'b0, 1'b0, 8'h5A, 1'b1);
		t_rx(2'h2, 1'b0, 1'b1, 8'hC3, 1'b1);
		t_rx(2'h3, 1'b1, 1'b0, 8'h0F, 1'b0);
		t_rx(2'h3, 1'b1, 1'b1, 8'hF0, 1'b1);
		t_shift(8'hB4);
		t_shift_rx(8'h6B);
		results();
	end
endmodule
`default_nettype wire
